// File: pkg/brr_pkg.sv
// Constants and types of the barometer result readout block
package brr_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS        = 40;
  localparam int CONV_UNIT_NS  = 250000;
  localparam int CONV_UNIT_CYC = (CONV_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int NVM_WAIT_NS   = 80000;
  localparam int NVM_WAIT_CYC  = (NVM_WAIT_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // Word map of the parameter store
  localparam logic [4:0] ADR_CUSTOMER_ID_WORD0          = 5'h00;
  localparam logic [4:0] ADR_CUSTOMER_ID_WORD1          = 5'h01;
  localparam logic [4:0] ADR_BUS_ADDRESS_WORD           = 5'h02;
  localparam logic [4:0] ADR_PRESSURE_COEF_HIGH_BITS    = 5'h03;
  localparam logic [4:0] ADR_TEMPERATURE_COEF_HIGH_BITS = 5'h04;
  localparam logic [4:0] ADR_PRESSURE_COEF2_LOW         = 5'h05;
  localparam logic [4:0] ADR_PRESSURE_COEF1_LOW         = 5'h06;
  localparam logic [4:0] ADR_PRESSURE_COEF4_LOW         = 5'h07;
  localparam logic [4:0] ADR_PRESSURE_COEF5_LOW         = 5'h08;
  localparam logic [4:0] ADR_PRESSURE_COEF7_LOW         = 5'h09;
  localparam logic [4:0] ADR_PRESSURE_COEF6_LOW         = 5'h0A;
  localparam logic [4:0] ADR_PRESSURE_COEF3_LOW         = 5'h0B;
  localparam logic [4:0] ADR_TEMPERATURE_COEF2_LOW      = 5'h0C;
  localparam logic [4:0] ADR_TEMPERATURE_COEF1_LOW      = 5'h0D;
  localparam logic [4:0] ADR_TEMPERATURE_COEF3_LOW      = 5'h0E;
  localparam logic [4:0] ADR_PRESSURE_COEF8_LOW         = 5'h0F;
  localparam logic [4:0] ADR_PRESSURE_COEF_MID_BITS_A   = 5'h10;
  localparam logic [4:0] ADR_AFE_DEFAULT                = 5'h14;
  localparam int         NVM_WORDS                      = 32;
  // ==========================================================
  // Fields
  localparam logic [6:0] BUS_ADDR_FALLBACK = 7'h78;
  localparam int         OSRT_LSB          = 14;
  localparam int         OSRP_LSB          = 11;
  localparam int         P8_HI_BIT         = 15;
  localparam int         P2_MID_LSB        = 8;
  localparam int         STAT_BUSY_BIT     = 5;
  localparam logic [7:0] CMD_FIRST         = 8'hA0;
  localparam logic [7:0] CMD_LAST          = 8'hA7;
  localparam int         CMD_TEMP_BIT      = 2;
  localparam int         CMD_OWNCFG_BIT    = 0;
  // Low word address and high field position, coefficient 1 at index 0
  localparam logic [6:0][4:0] PLOW_ADR =
    {5'h09, 5'h0A, 5'h08, 5'h07, 5'h0B, 5'h05, 5'h06};
  localparam logic [6:0][3:0] PHI_POS =
    {4'h8, 4'hA, 4'h6, 4'h4, 4'hC, 4'h0, 4'h2};
  localparam logic [2:0][4:0] TLOW_ADR = {5'h0E, 5'h0C, 5'h0D};
  localparam logic [2:0][3:0] THI_POS  = {4'h2, 4'h4, 4'h0};
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ADDR_ACK = 3'h3,
    ST_WR_BYTE = 3'h2, ST_WR_ACK = 3'h6, ST_RD_BYTE = 3'h7,
    ST_RD_ACK = 3'h5
  } brr_state_type;
  // Coefficient bits held in the window of the store
  typedef struct packed {
    logic [6:0][17:0] pres;     // {bits 25:24, bits 15:0}
    logic [16:0]      pres8;
    logic [7:0]       pres2Mid; // bits 23:16 of coefficient 2
    logic [2:0][17:0] temp;
  } brr_coef_type;
endpackage : brr_pkg

// File: design/brr_readout.sv
// Serial result readout, parameter store and coefficient map
`timescale 1ns/100ps
// Summary of operation
// - Valid trigger starts conversion, result buffered
// - Busy for oversampling-dependent conversion time
// - Pressure result is three bytes
// - Temperature read may stop after two bytes
// - Store holds 16-bit words, read whole
// - Bus address from word 2 bits 6:0
// - Zero stored address means address 0x78
// - Pressure coefficients 1-7 high bits word 3
// - Word 3 two-bit field placement
// - Coefficient 8 bit 16 in word 3
// - Pressure low words 0x05 to 0x0B
// - Coefficient 2 bits 23:16 word 0x10
// - Temperature high bits in word 4
// - Temperature low words 0x0C-0x0E
// - Store read: address, wait, status, data
module brr_readout #(
  parameter int unsigned CONV_UNIT_CYC = brr_pkg::CONV_UNIT_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  input  wire logic                  sclIn,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe,
  input  wire logic [23:0]           rawResult,
  input  wire logic                  nvmWrEn,
  input  wire logic [4:0]            nvmWrAddr,
  input  wire logic [15:0]           nvmWrData,
  output logic                       busy,
  output logic                       measTemp,
  output logic [15:0]                afeCfg,
  output brr_pkg::brr_coef_type      coef
);
  import brr_pkg::*;

  // ==========================================================
  // Pin synchronisers and bus conditions
  logic [1:0]    meta_ff;
  logic [1:0]    sync_ff;
  logic [1:0]    prev_ff;
  logic          sclRise;
  logic          sclFall;
  logic          startC;
  logic          stopC;
  logic [15:0]   nvm_ff [NVM_WORDS];
  logic [6:0]    devAddr;
  brr_state_type state_ff;
  logic [3:0]    cnt_ff;
  logic [7:0]    shift_ff;
  logic          rw_ff;
  logic          sel_ff;
  logic [2:0]    idx_ff;
  logic          sdaOe_ff;
  logic          cmdMode_ff;
  logic [7:0]    cmd_ff;
  logic [15:0]   cmdData_ff;
  logic [4:0]    nvmAddr_ff;
  logic          nvmMode_ff;
  logic [15:0]   nvmWord_ff;
  logic [23:0]   resultBuf_ff;
  logic [23:0]   busyCnt_ff;
  logic          busy_ff;
  logic          fetch_ff;
  logic          temp_ff;
  logic [15:0]   afe_ff;
  brr_coef_type  coef_ff;
  logic [7:0]    nxt_tx;
  logic          wrDone;
  logic          startConv;
  logic          startFetch;
  logic [15:0]   nxt_afe;
  logic [2:0]    convShift;
  logic [23:0]   convCyc;

  // SCL in bit 1, SDA in bit 0
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
      prev_ff <= 2'h3;
    end else if (ce) begin
      meta_ff <= {sclIn, sdaIn};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edges and start/stop, from the second and third stages
  assign sclRise = sync_ff[1] & ~prev_ff[1];
  assign sclFall = ~sync_ff[1] & prev_ff[1];
  assign startC  = sync_ff[1] & prev_ff[1] & prev_ff[0] & ~sync_ff[0];
  assign stopC   = sync_ff[1] & prev_ff[1] & ~prev_ff[0] & sync_ff[0];

  // ==========================================================
  // Parameter store, written only through the programming port
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NVM_WORDS; i++) begin
        nvm_ff[i] <= 16'h0000;
      end
    end else if (ce && nvmWrEn) begin
      nvm_ff[nvmWrAddr] <= nvmWrData;
    end
  end

  // Own bus address, fallback when the field is empty
  always_comb begin
    devAddr = nvm_ff[ADR_BUS_ADDRESS_WORD][6:0];
    if (devAddr == 7'h00) begin
      devAddr = BUS_ADDR_FALLBACK;
    end
  end

  // ==========================================================
  // Byte to send next: status first, then data MSB first
  always_comb begin
    nxt_tx = 8'hFF;
    if (idx_ff == 3'h0) begin
      nxt_tx = 8'({busy_ff} << STAT_BUSY_BIT);
    end else if (nvmMode_ff) begin
      if (idx_ff == 3'h1) begin
        nxt_tx = nvmWord_ff[15:8];
      end else if (idx_ff == 3'h2) begin
        nxt_tx = nvmWord_ff[7:0];
      end
    end else if (idx_ff == 3'h1) begin
      nxt_tx = resultBuf_ff[23:16];
    end else if (idx_ff == 3'h2) begin
      nxt_tx = resultBuf_ff[15:8];
    end else if (idx_ff == 3'h3) begin
      nxt_tx = resultBuf_ff[7:0];
    end
  end

  assign wrDone = (state_ff == ST_WR_BYTE) && sclFall && (cnt_ff == 4'h8);

  // ==========================================================
  // Bus slave state machine
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff    <= 1'b0;
      sel_ff   <= 1'b0;
      idx_ff   <= 3'h0;
      sdaOe_ff <= 1'b0;
    end else if (ce) begin
      if (startC) begin
        state_ff <= ST_ADDR;
        cnt_ff   <= 4'h0;
        sel_ff   <= 1'b0;
        idx_ff   <= 3'h0;
        sdaOe_ff <= 1'b0;
      end else if (stopC) begin
        state_ff <= ST_IDLE;
        sdaOe_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_ADDR, ST_WR_BYTE: begin
            if (sclRise) begin
              shift_ff <= {shift_ff[6:0], sync_ff[0]};
              cnt_ff   <= cnt_ff + 4'h1;
            end else if (sclFall && cnt_ff == 4'h8) begin
              if (state_ff == ST_WR_BYTE) begin
                state_ff <= ST_WR_ACK;
                sdaOe_ff <= 1'b1;
                if (idx_ff != 3'h4) begin
                  idx_ff <= idx_ff + 3'h1;
                end
              end else if (shift_ff[7:1] == devAddr) begin
                state_ff <= ST_ADDR_ACK;
                sdaOe_ff <= 1'b1;
                rw_ff    <= shift_ff[0];
                sel_ff   <= 1'b1;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK, ST_RD_ACK: begin
            if (sclRise && state_ff == ST_RD_ACK && sync_ff[0]) begin
              state_ff <= ST_IDLE;
            end else if (sclFall && rw_ff) begin
              state_ff <= ST_RD_BYTE;
              shift_ff <= nxt_tx;
              sdaOe_ff <= ~nxt_tx[7];
              cnt_ff   <= 4'h1;
              if (idx_ff != 3'h4) begin
                idx_ff <= idx_ff + 3'h1;
              end
            end else if (sclFall) begin
              state_ff <= ST_WR_BYTE;
              sdaOe_ff <= 1'b0;
              cnt_ff   <= 4'h0;
            end
          end
          ST_WR_ACK: begin
            if (sclFall) begin
              state_ff <= ST_WR_BYTE;
              sdaOe_ff <= 1'b0;
              cnt_ff   <= 4'h0;
            end
          end
          ST_RD_BYTE: begin
            if (sclFall && cnt_ff == 4'h8) begin
              state_ff <= ST_RD_ACK;
              sdaOe_ff <= 1'b0;
            end else if (sclFall) begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              sdaOe_ff <= ~shift_ff[6];
              cnt_ff   <= cnt_ff + 4'h1;
            end
          end
          default: begin
            sdaOe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Write bytes: command with data, or store word address
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cmdMode_ff <= 1'b0;
      cmd_ff     <= 8'h00;
      cmdData_ff <= 16'h0000;
      nvmAddr_ff <= 5'h00;
      nvmMode_ff <= 1'b0;
    end else if (ce && wrDone) begin
      if (idx_ff == 3'h0) begin
        if (shift_ff >= CMD_FIRST && shift_ff <= CMD_LAST) begin
          cmdMode_ff <= 1'b1;
          cmd_ff     <= shift_ff;
          nvmMode_ff <= 1'b0;
        end else begin
          cmdMode_ff <= 1'b0;
          nvmAddr_ff <= shift_ff[4:0];
          nvmMode_ff <= 1'b1;
        end
      end else if (idx_ff == 3'h1) begin
        cmdData_ff[15:8] <= shift_ff;
      end else if (idx_ff == 3'h2) begin
        cmdData_ff[7:0] <= shift_ff;
      end
    end
  end

  // Act at the stop that ends an addressed write
  assign startConv  = stopC && sel_ff && !rw_ff && cmdMode_ff &&
                      idx_ff == 3'h3 && !busy_ff;
  assign startFetch = stopC && sel_ff && !rw_ff && !cmdMode_ff &&
                      idx_ff == 3'h1 && !busy_ff;

  // Conversion length from the oversampling setting
  always_comb begin
    nxt_afe = cmd_ff[CMD_OWNCFG_BIT] ? cmdData_ff
                                     : nvm_ff[ADR_AFE_DEFAULT];
    if (cmd_ff[CMD_TEMP_BIT]) begin
      convShift = {1'b0, nxt_afe[OSRT_LSB+:2]} + 3'h2;
    end else begin
      convShift = ~nxt_afe[OSRP_LSB+:3];
    end
    convCyc = 24'(CONV_UNIT_CYC) << convShift;
  end

  // ==========================================================
  // Busy timer, result buffer and store fetch
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busyCnt_ff   <= 24'h000000;
      busy_ff      <= 1'b0;
      fetch_ff     <= 1'b0;
      temp_ff      <= 1'b0;
      afe_ff       <= 16'h0000;
      resultBuf_ff <= 24'h000000;
      nvmWord_ff   <= 16'h0000;
    end else if (ce) begin
      if (startConv) begin
        busyCnt_ff <= convCyc;
        busy_ff    <= 1'b1;
        fetch_ff   <= 1'b0;
        temp_ff    <= cmd_ff[CMD_TEMP_BIT];
        afe_ff     <= nxt_afe;
      end else if (startFetch) begin
        busyCnt_ff <= 24'(NVM_WAIT_CYC);
        busy_ff    <= 1'b1;
        fetch_ff   <= 1'b1;
      end else if (busy_ff && busyCnt_ff == 24'h000001) begin
        busy_ff    <= 1'b0;
        busyCnt_ff <= 24'h000000;
        if (fetch_ff) begin
          nvmWord_ff <= nvm_ff[nvmAddr_ff];
        end else begin
          resultBuf_ff <= rawResult;
        end
      end else if (busy_ff) begin
        busyCnt_ff <= busyCnt_ff - 24'h000001;
      end
    end
  end

  // ==========================================================
  // Coefficient fields gathered from the store
  for (genvar i = 0; i < 7; i++) begin : g_pres
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        coef_ff.pres[i] <= 18'h00000;
      end else if (ce) begin
        coef_ff.pres[i] <= {
          nvm_ff[ADR_PRESSURE_COEF_HIGH_BITS][PHI_POS[i]+:2],
          nvm_ff[PLOW_ADR[i]]};
      end
    end
  end
  for (genvar i = 0; i < 3; i++) begin : g_temp
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        coef_ff.temp[i] <= 18'h00000;
      end else if (ce) begin
        coef_ff.temp[i] <= {
          nvm_ff[ADR_TEMPERATURE_COEF_HIGH_BITS][THI_POS[i]+:2],
          nvm_ff[TLOW_ADR[i]]};
      end
    end
  end
  // Coefficient 8 and the middle byte of coefficient 2
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      coef_ff.pres8    <= 17'h00000;
      coef_ff.pres2Mid <= 8'h00;
    end else if (ce) begin
      coef_ff.pres8 <= {nvm_ff[ADR_PRESSURE_COEF_HIGH_BITS][P8_HI_BIT],
                        nvm_ff[ADR_PRESSURE_COEF8_LOW]};
      coef_ff.pres2Mid <=
        nvm_ff[ADR_PRESSURE_COEF_MID_BITS_A][P2_MID_LSB+:8];
    end
  end

  // Outputs straight from flip-flops, except sdaOut, tied low
  assign sdaOut   = 1'b0;
  assign sdaOe    = sdaOe_ff;
  assign busy     = busy_ff;
  assign measTemp = temp_ff;
  assign afeCfg   = afe_ff;
  assign coef     = coef_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_convStart;
    startConv && ce |=> busy_ff && busyCnt_ff == $past(convCyc);
  endproperty
  a_convStart: assert property (p_convStart)
    else $error("conversion did not start busy");

  property p_countDown;
    busy_ff && ce && busyCnt_ff > 24'h000001 && !startConv |=>
      busyCnt_ff == $past(busyCnt_ff) - 24'h000001 && busy_ff;
  endproperty
  a_countDown: assert property (p_countDown)
    else $error("busy timer misbehaved");

  property p_bufHold;
    busy_ff && busyCnt_ff != 24'h000001 |=> $stable(resultBuf_ff);
  endproperty
  a_bufHold: assert property (p_bufHold)
    else $error("result buffer changed while busy");

  property p_fallback;
    nvm_ff[ADR_BUS_ADDRESS_WORD][6:0] == 7'h00 |-> devAddr == 7'h78;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("fallback address not used");

  property p_addrAck;
    ce && state_ff == ST_ADDR && sclFall && cnt_ff == 4'h8 &&
      shift_ff[7:1] == nvm_ff[ADR_BUS_ADDRESS_WORD][6:0] &&
      shift_ff[7:1] != 7'h00 |=> sdaOe_ff && state_ff == ST_ADDR_ACK;
  endproperty
  a_addrAck: assert property (p_addrAck)
    else $error("own address not acknowledged");

  property p_msbFirst;
    ce && sclFall && rw_ff && state_ff == ST_RD_ACK && !nvmMode_ff &&
      idx_ff == 3'h1 |=> shift_ff == resultBuf_ff[23:16];
  endproperty
  a_msbFirst: assert property (p_msbFirst)
    else $error("result high byte not sent first");

  property p_nack;
    ce && state_ff == ST_RD_ACK && sclRise && sync_ff[0] && !startC
      |=> state_ff == ST_IDLE && !sdaOe_ff;
  endproperty
  a_nack: assert property (p_nack)
    else $error("read not ended on not-acknowledge");

  property p_coef3;
    ce |=> coef_ff.pres[2] ==
      {$past(nvm_ff[ADR_PRESSURE_COEF_HIGH_BITS][13:12]),
       $past(nvm_ff[ADR_PRESSURE_COEF3_LOW])};
  endproperty
  a_coef3: assert property (p_coef3)
    else $error("pressure coefficient 3 misplaced");

  property p_temp2;
    ce |=> coef_ff.temp[1] ==
      {$past(nvm_ff[ADR_TEMPERATURE_COEF_HIGH_BITS][5:4]),
       $past(nvm_ff[ADR_TEMPERATURE_COEF2_LOW])};
  endproperty
  a_temp2: assert property (p_temp2)
    else $error("temperature coefficient 2 misplaced");

  property p_fetch;
    ce && busy_ff && fetch_ff && busyCnt_ff == 24'h000001 |=>
      nvmWord_ff == $past(nvm_ff[nvmAddr_ff]) && !busy_ff;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("store word not fetched whole");
endmodule : brr_readout

// File: verification/brr_i2c_master.sv
// Bus master model: serial clock and open-drain data line of the readout
`timescale 1ns/100ps
module brr_i2c_master (
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sda
);
  // ==========================================================
  // Quarter of the 320 ns bus clock period
  localparam int Q = 80;

  // Bus idle: clock high and data released, so the pull-up holds it high
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high
  task automatic start_cond;
    sdaLow = 1'b0;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start_cond

  // Stop ends every frame; a command only takes effect here
  task automatic stop_cond;
    sdaLow = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sdaLow = 1'b0;
    #(2*Q);
  endtask : stop_cond

  // One bit: data changes mid-low, sampled mid-high; clock stops after
  task automatic bit_io(input logic b, output logic r);
    sdaLow = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_io

  // Byte out, most significant bit first, then sample the device ACK
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // Byte in; master ACKs all but the last, which it NACKs
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : brr_i2c_master

// File: verification/testbench.sv
// Self-checking testbench of the barometer result readout
`timescale 1ns/100ps
module testbench;
  import brr_pkg::*;
  // ==========================================================
  // Signals and design under test
  localparam int          UNIT = 4;
  localparam logic [15:0] W3   = 16'hB6E4;
  localparam logic [15:0] W4   = 16'h0036;
  logic         clk_sys, sys_rst, ce, nvmWrEn, scl, sdaLow;
  logic         sdaOut, sdaOe, busy, measTemp;
  logic [4:0]   nvmWrAddr;
  logic [15:0]  nvmWrData, afeCfg;
  logic [23:0]  rawResult, prevRes;
  logic [7:0]   cmd;
  brr_coef_type coef;
  wire          sda;
  int n_errors = 0, check_count = 0, busyRun = 0, busyLen = 0;
  int pPos[7] = '{2, 0, 12, 4, 6, 10, 8};
  int pLow[7] = '{6, 5, 11, 7, 8, 10, 9};
  int tPos[3] = '{0, 4, 2};
  int tLow[3] = '{13, 12, 14};

  // Wired-AND of the open-drain data line with its pull-up
  assign sda = ~(sdaLow | sdaOe);

  brr_readout #(.CONV_UNIT_CYC(UNIT)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .rawResult(rawResult),
    .nvmWrEn(nvmWrEn), .nvmWrAddr(nvmWrAddr), .nvmWrData(nvmWrData),
    .busy(busy), .measTemp(measTemp), .afeCfg(afeCfg), .coef(coef)
  );
  brr_i2c_master partner (.scl(scl), .sdaLow(sdaLow), .sda(sda));

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Length of the last busy run in clocks
  always @(posedge clk_sys) begin
    if (busy === 1'b1) begin
      busyRun <= busyRun + 1;
    end else if (busyRun != 0) begin
      busyLen <= busyRun;
      busyRun <= 0;
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Programming write of one store word
  task automatic nvm_wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    nvmWrEn   = 1'b1;
    nvmWrAddr = a;
    nvmWrData = d;
    @(negedge clk_sys);
    nvmWrEn = 1'b0;
  endtask : nvm_wr

  // Poll busy under a bound, then let the run length land
  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim && busy !== 1'b0; i++) begin
      @(negedge clk_sys);
    end
    if (busy !== 1'b0) begin
      n_errors++;
      $display("ERROR t=%0t busy never cleared", $time);
      report_and_stop;
    end
    repeat (2) @(negedge clk_sys);
  endtask : wait_idle

  // Write frame: address, then n bytes of d most significant first
  task automatic wr_xfer(input logic [6:0] a, input int n,
                         input logic [23:0] d, input logic expAck);
    logic ack;
    partner.start_cond;
    partner.wr_byte({a, 1'b0}, ack);
    chk(ack, expAck, "address ack");
    for (int i = n - 1; i >= 0 && ack; i--) begin
      partner.wr_byte(d[8*i+:8], ack);
      chk(ack, 1, "data ack");
    end
    partner.stop_cond;
  endtask : wr_xfer

  // Read frame: n bytes compared against exp, last one NACKed
  task automatic rd_xfer(input logic [6:0] a, input int n,
                         input logic [31:0] exp);
    logic       ack;
    logic [7:0] b;
    partner.start_cond;
    partner.wr_byte({a, 1'b1}, ack);
    chk(ack, 1, "read address ack");
    for (int k = 0; k < n; k++) begin
      partner.rd_byte(k == n - 1, b);
      chk(b, exp[8*(n-1-k)+:8], "read byte");
    end
    partner.stop_cond;
  endtask : rd_xfer

  // Hang guard
  initial begin
    #3000000;
    n_errors++;
    $display("ERROR t=%0t run limit reached", $time);
    report_and_stop;
  end

  // ==========================================================
  // Main sequence
  initial begin
    ce        = 1'b1;
    sys_rst   = 1'b1;
    nvmWrEn   = 1'b0;
    nvmWrAddr = 5'h00;
    nvmWrData = 16'h0000;
    rawResult = 24'h000000;
    prevRes   = 24'h000000;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(busy, 0, "busy after reset");
    chk(sdaOe, 0, "data released after reset");
    // Empty store answers on the fallback address only
    wr_xfer(7'h55, 0, 24'h0, 1'b0);
    rd_xfer(7'h78, 1, 32'h00);
    // Programmed address replaces the fallback; a legal code, not 0x04-0x07
    nvm_wr(ADR_BUS_ADDRESS_WORD, 16'h0055);
    wr_xfer(7'h78, 0, 24'h0, 1'b0);
    // Coefficient words; reserved bits kept zero
    nvm_wr(5'h03, W3);
    nvm_wr(5'h04, W4);
    for (int a = 5; a <= 15; a++) begin
      nvm_wr(5'(a), 16'hA500 | 16'(a));
    end
    nvm_wr(5'h10, 16'h5A00);
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 7; i++) begin
      chk(coef.pres[i], {W3[pPos[i]+:2], 16'hA500 | 16'(pLow[i])},
          "pressure coef");
    end
    chk(coef.pres8, {1'b1, 16'hA50F}, "coef 8");
    chk(coef.pres2Mid, 8'h5A, "coef 2 mid");
    for (int i = 0; i < 3; i++) begin
      chk(coef.temp[i], {W4[tPos[i]+:2], 16'hA500 | 16'(tLow[i])},
          "temperature coef");
    end
    // Store word read: address, wait out the fetch, status and word
    wr_xfer(7'h55, 1, 24'h00000D, 1'b1);
    repeat (2) @(negedge clk_sys);
    chk(busy, 1, "fetch busy");
    wait_idle(3000);
    rd_xfer(7'h55, 3, 32'h00A50D);
    // Every trigger code, store or own config, all result lengths
    nvm_wr(5'h14, 16'h0020);
    for (int c = 0; c < 8; c++) begin
      cmd       = CMD_FIRST + 8'(c);
      rawResult = {cmd, 8'h3C, 8'(c * 17)};
      wr_xfer(7'h55, 3, {cmd, 16'h3800}, 1'b1);
      repeat (2) @(negedge clk_sys);
      chk(measTemp, cmd[2], "kind");
      chk(afeCfg, cmd[0] ? 16'h3800 : 16'h0020, "config");
      if (c == 2) begin
        rd_xfer(7'h55, 4, {8'h20, prevRes});
      end
      wait_idle(2000);
      chk(busyLen, cmd[2] ? 16 : (cmd[0] ? 4 : 512), "time");
      if (cmd[2] && c == 4) begin
        rd_xfer(7'h55, 3, {8'h00, rawResult[23:8]});
      end else begin
        rd_xfer(7'h55, 4, {8'h00, rawResult});
      end
      prevRes = rawResult;
    end
    report_and_stop;
  end
endmodule : testbench
